// ### ecc_pkg.sv
// Constants, register map and field layout of the clock dividers and power status block.
// Assumes a 100 MHz reference clock and a simple word-wide register port.
`default_nettype none
package ecc_pkg;
   // Register port
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] OFS_CORE_DIV = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_HOST_DIV = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_CLK_CTRL = 8'h0c;
   localparam logic [DATA_W-1:0] READ_UNMAPPED = 32'h0000_0000;

   // Divider fields
   localparam int DIV_W = 4;
   localparam logic [DIV_W-1:0] CORE_DIV_RESET = 4'h8;
   localparam logic [DIV_W-1:0] CORE_DIV_MIN = 4'h2;
   localparam logic [DIV_W-1:0] HOST_DIV_RESET = 4'h1;
   localparam logic [DIV_W-1:0] HOST_DIV_MIN = 4'h1;

   // Status bit positions
   localparam int ST_SLOW = 0;
   localparam int ST_PCI = 1;
   localparam int ST_BAT_LOW = 2;
   localparam int ST_VCC_LOW = 3;
   localparam int ST_PWRGD = 4;
   localparam int ST_LOCK = 5;
   localparam int ST_LRESET = 7;
   localparam int ST_REF14 = 8;

   // Clock control layout
   localparam logic [DATA_W-1:0] CLK_CTRL_RESET = 32'h0000_0500;
   localparam int CC_SLEEP = 1;
   localparam int CC_SAA = 4;
   localparam int CC_OSC_LO = 8;
   localparam int CC_PLL_LO = 10;
   localparam int CTL_W = 2;

   typedef enum logic [1:0] {
      ECC_CTL_OFF = 2'h0,
      ECC_CTL_MANAGED = 2'h1,
      ECC_CTL_GATED = 2'h2,
      ECC_CTL_FORCED = 2'h3
   } ecc_ctl_t;

   // Supply sequence, one-bit steps except up to down
   typedef enum logic [1:0] {
      ECC_SUP_DOWN = 2'h0,
      ECC_SUP_SAMPLE = 2'h1,
      ECC_SUP_UP = 2'h3
   } ecc_sup_t;

   // Edge activity windows
   localparam int CLK_PERIOD_NS = 10;
   localparam int SLOW_WINDOW_NS = 100000;
   localparam int FAST_WINDOW_NS = 1000;
   localparam int SLOW_WINDOW_CYC = (SLOW_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FAST_WINDOW_CYC = (FAST_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// ### ecc_divider.sv
// Programmable clock-enable divider: one-cycle pulse every DIV input cycles.
// Assumes the divisor input is never zero; new values apply at a period boundary.
`timescale 1ns/1ps
`default_nettype none
module ecc_divider #(
   parameter int DIV_W = 4
) (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic [DIV_W-1:0] div_i,
   output logic pulse_o
);
   logic [DIV_W-1:0] count;
   logic [DIV_W-1:0] active_div;
   logic terminal;

   assign terminal = (count >= active_div - 1'b1);

   // Divisor taken only at wrap, so no period is shortened
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         count <= '0;
         active_div <= div_i;
      end else if (terminal) begin
         count <= '0;
         active_div <= div_i;
      end else begin
         count <= count + 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         pulse_o <= 1'b0;
      end else begin
         pulse_o <= terminal;
      end
   end
endmodule // ecc_divider
`default_nettype wire

// ### ecc_activity.sv
// Edge activity monitor: reports presence while edges arrive within a window.
// Assumes the monitored input is already synchronous to the reference clock.
`timescale 1ns/1ps
`default_nettype none
module ecc_activity #(
   parameter int WINDOW = 100
) (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic sig_i,
   output logic present_o
);
   localparam int CNT_W = $clog2(WINDOW + 1);
   localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(WINDOW);

   logic prev;
   logic [CNT_W-1:0] idle;
   logic seen;

   assign seen = (sig_i != prev);

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         prev <= 1'b0;
      end else begin
         prev <= sig_i;
      end
   end

   // Only edges count, frequency is not checked
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         idle <= CNT_MAX;
      end else if (seen) begin
         idle <= '0;
      end else if (idle != CNT_MAX) begin
         idle <= idle + 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         present_o <= 1'b0;
      end else begin
         present_o <= seen || (idle < CNT_MAX - 1'b1);
      end
   end
endmodule // ecc_activity
`default_nettype wire

// ### ecc_clock_ctrl.sv
// Core and host-bus clock dividers, power/clock status and clock control registers.
// Assumes a word-wide register port with one-cycle write and read strobes and
// pins already synchronous to ref_clk_i, except the power-good pin.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Core divider takes 2 to 15; writes of 0 or 1 change nothing.
// - Core divider resets to 8.
// - Core clock and core bus enable rate are master clock over divider.
// - Host bus divider takes 1 to 15; a write of 0 is ignored.
// - Host bus divider resets to 1; value 1 passes master clock undivided.
// - Host bus divider spans full master rate down to one fifteenth.
// - Slow clock present bit reports edges on the 32 kHz input.
// - Inverted slow clock present drives bit 6 of the interrupt group.
// - PCI clock present bit reports edges on the PCI clock input.
// - Battery sampled when main supply rises; low battery flag feeds runtime status.
// - Supply low bit follows detector; main supply reset while bit is 0.
// - Power good bit mirrors the pin after synchronisation.
// - Oscillator lock bit reports tight tolerance against the reference.
// - Status bit reflects the LPC reset pin level.
// - 14 MHz present bit reports edges on the 14 MHz input.
// - Status bits at D7, D5, D4, D3, D2, D1, D0, D8; read only.
// - Clock control resets to 0500h with PLL, oscillator, auto adjust, sleep fields.
// - Oscillator control: off, managed by sleep, gated in sleep, forced on.
// - PLL control: off, follows power good, gated without power good, forced on.
// - Firmware sets sleep flag; a wake event clears it.
// - Stop auto adjust bit disables oscillator frequency correction.
module ecc_clock_ctrl #(
   parameter int SLOW_WINDOW = ecc_pkg::SLOW_WINDOW_CYC,
   parameter int FAST_WINDOW = ecc_pkg::FAST_WINDOW_CYC
) (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic [ecc_pkg::ADDR_W-1:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [ecc_pkg::DATA_W-1:0] reg_wdata_i,
   output logic [ecc_pkg::DATA_W-1:0] reg_rdata_o,
   output logic reg_rvalid_o,
   input wire logic slow_clock_i,
   input wire logic pci_clock_i,
   input wire logic ref14_clock_i,
   input wire logic power_supply_good_i,
   input wire logic vcc_below_trip_i,
   input wire logic battery_below_trip_i,
   input wire logic osc_lock_i,
   input wire logic lreset_n_i,
   input wire logic wake_i,
   input wire logic sleep_state_i,
   input wire logic main_power_good_i,
   output logic core_clock_enable_o,
   output logic core_bus_clock_enable_o,
   output logic host_bus_clock_enable_o,
   output logic slow_clock_absent_o,
   output logic battery_low_o,
   output logic main_supply_reset_o,
   output logic osc_enable_o,
   output logic mclk_tree_enable_o,
   output logic pll_enable_o,
   output logic pll_tree_enable_o,
   output logic auto_adjust_enable_o,
   output logic sleep_flag_o
);
   import ecc_pkg::*;

   logic [DIV_W-1:0] core_divider_value;
   logic [DIV_W-1:0] host_bus_divider_value;
   logic core_pulse;
   logic host_pulse;
   logic slow_clock_present;
   logic pci_clock_present;
   logic ref14_clock_present;
   logic pwrgd_meta;
   logic power_supply_good;
   logic vcc_low;
   logic battery_low;
   logic osc_lock_status;
   logic lreset_level;
   ecc_sup_t sup_state;
   ecc_sup_t next_sup_state;
   ecc_ctl_t osc_control_field;
   ecc_ctl_t pll_control_field;
   logic stop_auto_adjust;
   logic sleep_flag;
   logic wr_core;
   logic wr_host;
   logic wr_ctrl;
   logic [DATA_W-1:0] status_word;
   logic [DATA_W-1:0] ctrl_word;
   logic [DATA_W-1:0] next_rdata;

   function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
      hit = (addr == ofs);
   endfunction

   function automatic logic [DIV_W-1:0] div_field(input logic [DATA_W-1:0] word);
      div_field = word[DIV_W-1:0];
   endfunction

   assign wr_core = reg_wr_i && hit(reg_addr_i, OFS_CORE_DIV);
   assign wr_host = reg_wr_i && hit(reg_addr_i, OFS_HOST_DIV);
   assign wr_ctrl = reg_wr_i && hit(reg_addr_i, OFS_CLK_CTRL);

   // Divider registers; out-of-range writes leave the value alone
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         core_divider_value <= CORE_DIV_RESET;
      end else if (wr_core && div_field(reg_wdata_i) >= CORE_DIV_MIN) begin
         core_divider_value <= div_field(reg_wdata_i);
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         host_bus_divider_value <= HOST_DIV_RESET;
      end else if (wr_host && div_field(reg_wdata_i) >= HOST_DIV_MIN) begin
         host_bus_divider_value <= div_field(reg_wdata_i);
      end
   end

   ecc_divider #(
      .DIV_W(DIV_W)
   ) u_core_div (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .div_i(core_divider_value),
      .pulse_o(core_pulse)
   );

   ecc_divider #(
      .DIV_W(DIV_W)
   ) u_host_div (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .div_i(host_bus_divider_value),
      .pulse_o(host_pulse)
   );

   // Core clock and core bus enable share one divider
   assign core_clock_enable_o = core_pulse;
   assign core_bus_clock_enable_o = core_pulse;
   assign host_bus_clock_enable_o = host_pulse;

   ecc_activity #(
      .WINDOW(SLOW_WINDOW)
   ) u_slow_act (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .sig_i(slow_clock_i),
      .present_o(slow_clock_present)
   );

   ecc_activity #(
      .WINDOW(FAST_WINDOW)
   ) u_pci_act (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .sig_i(pci_clock_i),
      .present_o(pci_clock_present)
   );

   ecc_activity #(
      .WINDOW(FAST_WINDOW)
   ) u_ref14_act (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .sig_i(ref14_clock_i),
      .present_o(ref14_clock_present)
   );

   // Power-good pin is asynchronous: two-stage synchroniser
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         pwrgd_meta <= 1'b0;
         power_supply_good <= 1'b0;
      end else begin
         pwrgd_meta <= power_supply_good_i;
         power_supply_good <= pwrgd_meta;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         vcc_low <= 1'b1;
         osc_lock_status <= 1'b0;
         lreset_level <= 1'b0;
      end else begin
         vcc_low <= vcc_below_trip_i;
         osc_lock_status <= osc_lock_i;
         lreset_level <= lreset_n_i;
      end
   end

   // Supply sequence: battery is sampled once per supply rise
   always_comb begin
      next_sup_state = sup_state;
      unique case (sup_state)
         ECC_SUP_DOWN: begin
            if (!vcc_low) begin
               next_sup_state = ECC_SUP_SAMPLE;
            end
         end
         ECC_SUP_SAMPLE: begin
            next_sup_state = vcc_low ? ECC_SUP_DOWN : ECC_SUP_UP;
         end
         ECC_SUP_UP: begin
            if (vcc_low) begin
               next_sup_state = ECC_SUP_DOWN;
            end
         end
         default: begin
            next_sup_state = ECC_SUP_DOWN;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         sup_state <= ECC_SUP_DOWN;
      end else begin
         sup_state <= next_sup_state;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         battery_low <= 1'b0;
      end else if (sup_state == ECC_SUP_SAMPLE) begin
         battery_low <= battery_below_trip_i;
      end
   end

   // Clock control fields
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         osc_control_field <= ecc_ctl_t'(CLK_CTRL_RESET[CC_OSC_LO +: CTL_W]);
         pll_control_field <= ecc_ctl_t'(CLK_CTRL_RESET[CC_PLL_LO +: CTL_W]);
         stop_auto_adjust <= CLK_CTRL_RESET[CC_SAA];
      end else if (wr_ctrl) begin
         osc_control_field <= ecc_ctl_t'(reg_wdata_i[CC_OSC_LO +: CTL_W]);
         pll_control_field <= ecc_ctl_t'(reg_wdata_i[CC_PLL_LO +: CTL_W]);
         stop_auto_adjust <= reg_wdata_i[CC_SAA];
      end
   end

   // Firmware set wins over a wake in the same cycle
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         sleep_flag <= CLK_CTRL_RESET[CC_SLEEP];
      end else if (wr_ctrl) begin
         sleep_flag <= reg_wdata_i[CC_SLEEP];
      end else if (wake_i) begin
         sleep_flag <= 1'b0;
      end
   end

   // Oscillator and PLL control decode
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         osc_enable_o <= 1'b1;
         mclk_tree_enable_o <= 1'b1;
      end else begin
         unique case (osc_control_field)
            ECC_CTL_OFF: begin
               osc_enable_o <= 1'b0;
               mclk_tree_enable_o <= 1'b0;
            end
            ECC_CTL_MANAGED: begin
               osc_enable_o <= !sleep_state_i || wake_i;
               mclk_tree_enable_o <= !sleep_state_i || wake_i;
            end
            ECC_CTL_GATED: begin
               osc_enable_o <= 1'b1;
               mclk_tree_enable_o <= !sleep_state_i || wake_i;
            end
            ECC_CTL_FORCED: begin
               osc_enable_o <= 1'b1;
               mclk_tree_enable_o <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         pll_enable_o <= 1'b0;
         pll_tree_enable_o <= 1'b0;
      end else begin
         unique case (pll_control_field)
            ECC_CTL_OFF: begin
               pll_enable_o <= 1'b0;
               pll_tree_enable_o <= 1'b0;
            end
            ECC_CTL_MANAGED: begin
               pll_enable_o <= main_power_good_i;
               pll_tree_enable_o <= main_power_good_i;
            end
            ECC_CTL_GATED: begin
               pll_enable_o <= 1'b1;
               pll_tree_enable_o <= main_power_good_i;
            end
            ECC_CTL_FORCED: begin
               pll_enable_o <= 1'b1;
               pll_tree_enable_o <= 1'b1;
            end
         endcase
      end
   end

   // Status side outputs
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         slow_clock_absent_o <= 1'b1;
         battery_low_o <= 1'b0;
         main_supply_reset_o <= 1'b0;
         auto_adjust_enable_o <= 1'b1;
         sleep_flag_o <= 1'b0;
      end else begin
         slow_clock_absent_o <= !slow_clock_present;
         battery_low_o <= battery_low;
         main_supply_reset_o <= !vcc_low;
         auto_adjust_enable_o <= !stop_auto_adjust;
         sleep_flag_o <= sleep_flag;
      end
   end

   // Read words; unlisted bits read zero
   always_comb begin
      status_word = '0;
      status_word[ST_SLOW] = slow_clock_present;
      status_word[ST_PCI] = pci_clock_present;
      status_word[ST_BAT_LOW] = battery_low;
      status_word[ST_VCC_LOW] = vcc_low;
      status_word[ST_PWRGD] = power_supply_good;
      status_word[ST_LOCK] = osc_lock_status;
      status_word[ST_LRESET] = lreset_level;
      status_word[ST_REF14] = ref14_clock_present;
   end

   always_comb begin
      ctrl_word = '0;
      ctrl_word[CC_OSC_LO +: CTL_W] = osc_control_field;
      ctrl_word[CC_PLL_LO +: CTL_W] = pll_control_field;
      ctrl_word[CC_SAA] = stop_auto_adjust;
      ctrl_word[CC_SLEEP] = sleep_flag;
   end

   always_comb begin
      next_rdata = READ_UNMAPPED;
      if (hit(reg_addr_i, OFS_CORE_DIV)) begin
         next_rdata[DIV_W-1:0] = core_divider_value;
      end else if (hit(reg_addr_i, OFS_HOST_DIV)) begin
         next_rdata[DIV_W-1:0] = host_bus_divider_value;
      end else if (hit(reg_addr_i, OFS_STATUS)) begin
         next_rdata = status_word;
      end else if (hit(reg_addr_i, OFS_CLK_CTRL)) begin
         next_rdata = ctrl_word;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         reg_rdata_o <= READ_UNMAPPED;
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rvalid_o <= reg_rd_i;
         if (reg_rd_i) begin
            reg_rdata_o <= next_rdata;
         end
      end
   end
endmodule // ecc_clock_ctrl
`default_nettype wire

// ### ecc_clock_ctrl_asserts.sv
// Checker for the clock dividers and power status block.
// Sees only the top module's ports; bound to every ecc_clock_ctrl instance.
`timescale 1ns/1ps
`default_nettype none
module ecc_clock_ctrl_asserts (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic [ecc_pkg::ADDR_W-1:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [ecc_pkg::DATA_W-1:0] reg_wdata_i,
   input wire logic reg_rvalid_o,
   input wire logic vcc_below_trip_i,
   input wire logic wake_i,
   input wire logic core_clock_enable_o,
   input wire logic core_bus_clock_enable_o,
   input wire logic main_supply_reset_o,
   input wire logic osc_enable_o,
   input wire logic mclk_tree_enable_o,
   input wire logic pll_enable_o,
   input wire logic pll_tree_enable_o,
   input wire logic auto_adjust_enable_o,
   input wire logic sleep_flag_o
);
   import ecc_pkg::*;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);

   // Cycles since the last core pulse
   logic [4:0] gap;
   logic seen;
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         gap <= 5'h00;
         seen <= 1'b0;
      end else if (core_clock_enable_o) begin
         gap <= 5'h01;
         seen <= 1'b1;
      end else if (gap != 5'h1f) begin
         gap <= gap + 5'h01;
      end
   end

   sequence s_ctl_wr;
      reg_wr_i && reg_addr_i == OFS_CLK_CTRL;
   endsequence
   sequence s_wake_alone;
      wake_i && !(reg_wr_i && reg_addr_i == OFS_CLK_CTRL);
   endsequence

   property p_rvalid;
      1'b1 |=> reg_rvalid_o == $past(reg_rd_i);
   endproperty
   a_rvalid: assert property (p_rvalid) else $error("read answer not one cycle after strobe");
   property p_core_bus;
      core_clock_enable_o == core_bus_clock_enable_o;
   endproperty
   a_core_bus: assert property (p_core_bus) else $error("core and core bus enables differ");
   property p_core_single;
      core_clock_enable_o |=> !core_clock_enable_o;
   endproperty
   a_core_single: assert property (p_core_single) else $error("core pulse longer than one cycle");
   property p_core_period;
      core_clock_enable_o && seen |-> gap >= 5'h02 && gap <= 5'h0f;
   endproperty
   a_core_period: assert property (p_core_period) else $error("core period outside 2 to 15");
   property p_supply;
      $stable(vcc_below_trip_i) [*5] |-> main_supply_reset_o == !vcc_below_trip_i;
   endproperty
   a_supply: assert property (p_supply) else $error("supply reset does not follow detector");
   property p_osc_forced;
      s_ctl_wr ##0 reg_wdata_i[9:8] == 2'h3 |-> ##2 osc_enable_o && mclk_tree_enable_o;
   endproperty
   a_osc_forced: assert property (p_osc_forced) else $error("forced oscillator not on");
   property p_pll_off;
      s_ctl_wr ##0 reg_wdata_i[11:10] == 2'h0 |-> ##2 !pll_enable_o && !pll_tree_enable_o;
   endproperty
   a_pll_off: assert property (p_pll_off) else $error("pll not off");
   property p_saa;
      s_ctl_wr ##0 reg_wdata_i[4] |-> ##2 !auto_adjust_enable_o;
   endproperty
   a_saa: assert property (p_saa) else $error("auto adjust still enabled");
   property p_wake;
      s_wake_alone |-> ##2 !sleep_flag_o;
   endproperty
   a_wake: assert property (p_wake) else $error("wake did not clear sleep flag");
endmodule // ecc_clock_ctrl_asserts

bind ecc_clock_ctrl ecc_clock_ctrl_asserts u_asserts (.*);
`default_nettype wire

// ### test_ec_clock_dividers_and_pcr_status.sv
// Self-checking bench for the clock dividers and power status block.
// Drives every port directly; activity windows shortened by parameter.
`timescale 1ns/1ps
`default_nettype none
module test_ec_clock_dividers_and_pcr_status;
   import ecc_pkg::*;
   logic ref_clk_i, resetn_i, reg_wr_i, reg_rd_i, reg_rvalid_o, tgl_en;
   logic [ADDR_W-1:0] reg_addr_i;
   logic [DATA_W-1:0] reg_wdata_i, reg_rdata_o, rd;
   logic slow_clock_i, pci_clock_i, ref14_clock_i, power_supply_good_i, vcc_below_trip_i;
   logic battery_below_trip_i, osc_lock_i, lreset_n_i, wake_i, sleep_state_i, main_power_good_i;
   logic core_clock_enable_o, core_bus_clock_enable_o, host_bus_clock_enable_o;
   logic slow_clock_absent_o, battery_low_o, main_supply_reset_o, osc_enable_o;
   logic mclk_tree_enable_o, pll_enable_o, pll_tree_enable_o, auto_adjust_enable_o, sleep_flag_o;
   int fail_count, n_compared, p;
   // Rows: address, write data, read back, pulse period (0 = none)
   localparam int NR = 12;
   localparam logic [7:0] RA [NR] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04,
      8'h04, 8'h04, 8'h04, 8'h0c, 8'h0c, 8'h10};
   localparam logic [31:0] RW [NR] = '{32'h3, 32'h1, 32'h0, 32'hffff_fff2, 32'hf, 32'h4,
      32'h0, 32'hf, 32'h1, 32'hffff_ffff, 32'h500, 32'hffff_ffff};
   localparam logic [31:0] RE [NR] = '{32'h3, 32'h3, 32'h3, 32'h2, 32'hf, 32'h4,
      32'h4, 32'hf, 32'h1, 32'hf12, 32'h500, 32'h0};
   localparam int RP [NR] = '{3, 3, 0, 2, 15, 4, 4, 0, 1, 0, 0, 0};

   ecc_clock_ctrl #(.SLOW_WINDOW(40), .FAST_WINDOW(8)) dut (.*);

   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   // Test clocks: fast ones every cycle, slow one every 10 cycles
   always @(posedge ref_clk_i) begin
      #1;
      if (tgl_en) begin
         pci_clock_i = ~pci_clock_i;
         ref14_clock_i = ~ref14_clock_i;
         if ($time % 100 < 10) begin
            slow_clock_i = ~slow_clock_i;
         end
      end
   end

   task finish_test;
      if (fail_count == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      cyc(1);
      reg_wr_i = 1'b1;
      reg_addr_i = a;
      reg_wdata_i = d;
      cyc(1);
      reg_wr_i = 1'b0;
   endtask
   task rdreg(input logic [7:0] a);
      cyc(1);
      reg_rd_i = 1'b1;
      reg_addr_i = a;
      cyc(1);
      reg_rd_i = 1'b0;
      check(reg_rvalid_o, 1'b1);
      rd = reg_rdata_o;
   endtask
   task do_reset;
      resetn_i = 1'b0;
      cyc(5);
      resetn_i = 1'b1;
   endtask
   // Cycles between two successive pulses, bounded
   task period(input bit host);
      p = -1;
      repeat (40) begin
         cyc(1);
         if (p >= 0) begin
            p++;
         end
         if ((host ? host_bus_clock_enable_o : core_bus_clock_enable_o) === 1'b1) begin
            if (p > 0) begin
               return;
            end
            p = 0;
         end
      end
      fail_count++;
      finish_test();
   endtask

   initial begin
      {reg_wr_i, reg_rd_i, tgl_en, slow_clock_i, pci_clock_i, ref14_clock_i} = 6'h0;
      {power_supply_good_i, osc_lock_i, wake_i, sleep_state_i, main_power_good_i} = 5'h0;
      {vcc_below_trip_i, battery_below_trip_i, lreset_n_i} = 3'h7;
      reg_addr_i = 8'h00;
      reg_wdata_i = 32'h0;
      fail_count = 0;
      n_compared = 0;
      do_reset();
      for (int i = 0; i < NR; i++) begin
         wr(RA[i], RW[i]);
         rdreg(RA[i]);
         check(rd, RE[i]);
         if (RP[i] != 0) begin
            period(RA[i] == 8'h04);
            check(p, RP[i]);
         end
      end
      // Oscillator and pll codes while asleep without power good
      sleep_state_i = 1'b1;
      for (int c = 0; c < 4; c++) begin
         wr(OFS_CLK_CTRL, {20'h0, c[1:0], c[1:0], 8'h0});
         cyc(2);
         check(osc_enable_o, c >= 2);
         check(pll_enable_o, c >= 2);
         if (c >= 2) begin
            check(mclk_tree_enable_o, c == 3);
            check(pll_tree_enable_o, c == 3);
         end
      end
      sleep_state_i = 1'b0;
      main_power_good_i = 1'b1;
      wr(OFS_CLK_CTRL, 32'h510);
      cyc(2);
      check({osc_enable_o, mclk_tree_enable_o, pll_enable_o}, 3'h7);
      check(auto_adjust_enable_o, 1'b0);
      // Sleep flag set by write, cleared by wake
      wr(OFS_CLK_CTRL, 32'h502);
      cyc(1);
      check(sleep_flag_o, 1'b1);
      wake_i = 1'b1;
      cyc(1);
      wake_i = 1'b0;
      cyc(2);
      check(sleep_flag_o, 1'b0);
      rdreg(OFS_CLK_CTRL);
      check(rd, 32'h500);
      // Status with everything present, battery sampled low at supply rise
      {tgl_en, power_supply_good_i, osc_lock_i, vcc_below_trip_i} = 4'he;
      cyc(10);
      battery_below_trip_i = 1'b0;
      cyc(50);
      wr(OFS_STATUS, 32'hffff_ffff);
      rdreg(OFS_STATUS);
      check(rd, 32'h1b7);
      check({battery_low_o, slow_clock_absent_o, main_supply_reset_o}, 3'h5);
      // Everything absent or low
      {tgl_en, power_supply_good_i, osc_lock_i, lreset_n_i, vcc_below_trip_i} = 5'h1;
      cyc(60);
      rdreg(OFS_STATUS);
      check(rd, 32'hc);
      check({slow_clock_absent_o, main_supply_reset_o}, 2'h2);
      // Second reset in mid-run restores defaults
      do_reset();
      for (int i = 0; i < 3; i++) begin
         rdreg(i == 2 ? OFS_CLK_CTRL : 8'(i * 4));
         check(rd, i == 0 ? 32'h8 : i == 1 ? 32'h1 : 32'h500);
      end
      period(1'b0);
      check(p, 8);
      check(core_clock_enable_o, 1'b1);
      period(1'b1);
      check(p, 1);
      finish_test();
   end
endmodule // test_ec_clock_dividers_and_pcr_status
`default_nettype wire
